// ===== src/cpu_address_generation.sv
// Program counter target and operand effective address generation
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Absolute call/branch loads 16-bit immediate into PC
// - Table call reads vector 40H-7FH, loads PC
// - Branch through register copies accumulator pair
// - Direct mode uses 16-bit immediate as address
// - Short direct reaches FE20H-FF1FH with 8 bits
// - Bit 8 set for 00H-1FH, else cleared
// - RAM FE20H-FEFFH, registers FF00H-FF1FH
// - Special register form covers FF00H-FFCFH, FFE0H-FFFFH
// - FF00H-FF1FH reachable both ways
// - Register mode picks one of eight by 3-bit code
// - Registers X,A,C,B,E,D,L,H; pairs 0-3 follow
// - Indirect uses pointer pair two or base pair
// - Based adds zero-extended byte, carry dropped
// - Stack addressed through stack pointer automatically
module cpu_address_generation #(
    parameter int ADDR_W = cpu_address_generation_pkg::ADDR_W
) (
    input wire logic clk,                        // Core clock
    input wire logic srst,                       // Synchronous reset, active high
    input wire logic ce,                         // Clock enable, freezes all state when low unless srst is high
    input wire logic req_valid,                  // Decode stage presents a request
    input wire cpu_address_generation_pkg::mode_t req_mode,  // Addressing mode
    input wire logic [7:0] opcode,               // First opcode byte
    input wire logic [15:0] absolute_address_field,  // 16-bit immediate
    input wire logic [7:0] byte_field,           // 8-bit immediate or displacement
    input wire logic [2:0] reg_code,             // General register code
    input wire logic use_base_pair,              // Indirect: base pair when high, pair two when low
    input wire logic word_access,                // Operand is 16 bits wide
    input wire logic [63:0] gpr,                 // Eight general registers, register n at byte n
    input wire logic [15:0] sp,                  // Stack pointer
    input wire logic tbl_valid,                  // Vector word returned by memory
    input wire logic [15:0] tbl_data,            // Stored branch target
    output logic busy,                           // Request cannot be taken
    output logic pc_load,                        // One-cycle PC load strobe
    output logic [15:0] pc_target,               // New program counter
    output logic ea_valid,                       // One-cycle operand address strobe
    output logic [15:0] ea,                      // Operand effective address
    output logic ea_is_sfr,                      // Address lies in register area
    output logic [2:0] reg_index,                // Selected general register
    output logic [7:0] reg_data,                 // Selected general register contents
    output logic tbl_rd_req,                     // Vector word read request, level
    output logic [15:0] tbl_addr,                // Vector word address
    output logic addr_error                      // One-cycle strobe: illegal operand address or undefined mode code
);

    // ==========================================================
    // Types and state
    // ==========================================================
    typedef enum logic [1:0] {
        ST_IDLE,      // Ready for a request
        ST_TABLE_RD   // Waiting for the vector word
    } fsm_t;

    typedef struct packed {
        fsm_t fsm;               // Sequencer state
        logic pc_load;           // PC load strobe
        logic [15:0] pc_target;  // Branch target
        logic ea_valid;          // Address strobe
        logic [15:0] ea;         // Effective address
        logic ea_is_sfr;         // Register area flag
        logic [2:0] reg_index;   // Register selection
        logic [7:0] reg_data;    // Register contents
        logic tbl_rd_req;        // Vector read request
        logic [15:0] tbl_addr;   // Vector address
        logic addr_error;        // Illegal address flag
    } state_t;

    state_t st;       // Registered state
    state_t next_st;  // Next state

    // ==========================================================
    // Decoding helpers
    // ==========================================================
    // Byte n of the register file
    function automatic logic [7:0] reg_byte(input logic [63:0] file, input logic [2:0] code);
        reg_byte = file[code*cpu_address_generation_pkg::BYTE_W +: cpu_address_generation_pkg::BYTE_W];
    endfunction : reg_byte

    // Pair p is {register 2p+1, register 2p}
    function automatic logic [15:0] reg_pair(input logic [63:0] file, input logic [1:0] p);
        reg_pair = {reg_byte(file, {p, 1'b1}), reg_byte(file, {p, 1'b0})};
    endfunction : reg_pair

    // Short direct: ones above, bit 8 from range, field below
    function automatic logic [15:0] short_addr(input logic [7:0] f);
        short_addr = {cpu_address_generation_pkg::SHORT_HIGH,
                      (f < cpu_address_generation_pkg::SHORT_SFR_LIMIT), f};
    endfunction : short_addr

    // ==========================================================
    // Next-state logic
    // ==========================================================
    // Strobes clear each cycle; results hold until the next request
    always_comb
    begin
        next_st = st;
        next_st.pc_load = 1'b0;
        next_st.ea_valid = 1'b0;
        next_st.addr_error = 1'b0;
        unique case (st.fsm)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    unique case (req_mode)
                        cpu_address_generation_pkg::MODE_ABS_BRANCH:
                        begin
                            // Anywhere in the space
                            next_st.pc_load = 1'b1;
                            next_st.pc_target = absolute_address_field;
                        end
                        cpu_address_generation_pkg::MODE_TABLE_CALL:
                        begin
                            // Word-aligned vector, index taken from opcode bits 5..1
                            next_st.tbl_addr = {cpu_address_generation_pkg::TABLE_BASE_HIGH,
                                opcode[cpu_address_generation_pkg::VEC_MSB:cpu_address_generation_pkg::VEC_LSB],
                                1'b0};
                            next_st.tbl_rd_req = 1'b1;
                            next_st.fsm = ST_TABLE_RD;
                        end
                        cpu_address_generation_pkg::MODE_REG_BRANCH:
                        begin
                            next_st.pc_load = 1'b1;
                            next_st.pc_target = reg_pair(gpr, cpu_address_generation_pkg::PAIR_ACC);
                        end
                        cpu_address_generation_pkg::MODE_DIRECT:
                        begin
                            next_st.ea_valid = 1'b1;
                            next_st.ea = absolute_address_field;
                            next_st.ea_is_sfr = (absolute_address_field[15:8] == cpu_address_generation_pkg::SFR_HIGH);
                        end
                        cpu_address_generation_pkg::MODE_SHORT:
                        begin
                            next_st.ea_valid = 1'b1;
                            next_st.ea = short_addr(byte_field);
                            // Low fields land on registers, the rest on RAM
                            next_st.ea_is_sfr = (byte_field < cpu_address_generation_pkg::SHORT_SFR_LIMIT);
                            // Odd word address is a software fault; flag it, still drive it
                            next_st.addr_error = word_access & byte_field[0];
                        end
                        cpu_address_generation_pkg::MODE_SFR:
                        begin
                            next_st.ea_valid = 1'b1;
                            next_st.ea = {cpu_address_generation_pkg::SFR_HIGH, byte_field};
                            next_st.ea_is_sfr = 1'b1;
                            // The hole between the two areas is not reachable
                            next_st.addr_error = (byte_field >= cpu_address_generation_pkg::SFR_HOLE_LO) &&
                                                 (byte_field <= cpu_address_generation_pkg::SFR_HOLE_HI);
                        end
                        cpu_address_generation_pkg::MODE_REG:
                        begin
                            // Register operand: no memory address
                            next_st.reg_index = reg_code;
                            next_st.reg_data = reg_byte(gpr, reg_code);
                        end
                        cpu_address_generation_pkg::MODE_INDIRECT:
                        begin
                            next_st.ea_valid = 1'b1;
                            next_st.ea = reg_pair(gpr, use_base_pair ? cpu_address_generation_pkg::PAIR_BASE
                                                                    : cpu_address_generation_pkg::PAIR_TWO);
                            next_st.ea_is_sfr = (next_st.ea[15:8] == cpu_address_generation_pkg::SFR_HIGH);
                        end
                        cpu_address_generation_pkg::MODE_BASED:
                        begin
                            // Sum truncated to 16 bits, so the carry is lost
                            next_st.ea_valid = 1'b1;
                            next_st.ea = 16'(reg_pair(gpr, cpu_address_generation_pkg::PAIR_BASE)
                                             + {8'h00, byte_field});
                            next_st.ea_is_sfr = (next_st.ea[15:8] == cpu_address_generation_pkg::SFR_HIGH);
                        end
                        cpu_address_generation_pkg::MODE_STACK_PUSH:
                        begin
                            // Writes go below the current top
                            next_st.ea_valid = 1'b1;
                            next_st.ea = 16'(sp - cpu_address_generation_pkg::STACK_STEP);
                            next_st.ea_is_sfr = 1'b0;
                        end
                        cpu_address_generation_pkg::MODE_STACK_POP:
                        begin
                            next_st.ea_valid = 1'b1;
                            next_st.ea = sp;
                            next_st.ea_is_sfr = 1'b0;
                        end
                        default:
                        begin
                            // Undefined mode code: report and ignore
                            next_st.addr_error = 1'b1;
                        end
                    endcase
                end
            end
            ST_TABLE_RD:
            begin
                // Hold the read until memory answers, then branch
                if (tbl_valid)
                begin
                    next_st.tbl_rd_req = 1'b0;
                    next_st.pc_load = 1'b1;
                    next_st.pc_target = tbl_data;
                    next_st.fsm = ST_IDLE;
                end
            end
            default:
            begin
                next_st.fsm = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Reset wins over the enable; everything else freezes while ce is low
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st <= '0;
            st.fsm <= ST_IDLE;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign busy = (st.fsm != ST_IDLE);
    assign pc_load = st.pc_load;
    assign pc_target = st.pc_target;
    assign ea_valid = st.ea_valid;
    assign ea = st.ea;
    assign ea_is_sfr = st.ea_is_sfr;
    assign reg_index = st.reg_index;
    assign reg_data = st.reg_data;
    assign tbl_rd_req = st.tbl_rd_req;
    assign tbl_addr = st.tbl_addr;
    assign addr_error = st.addr_error;

endmodule : cpu_address_generation
`default_nettype wire

// ===== src/cpu_address_generation_pkg.sv
// Constants and types shared by the address generation logic
package cpu_address_generation_pkg;

    // ==========================================================
    // Addressing modes presented by the decode stage
    // ==========================================================
    typedef enum logic [3:0] {
        MODE_ABS_BRANCH,  // Absolute call or branch
        MODE_TABLE_CALL,  // Table vector call
        MODE_REG_BRANCH,  // Branch through accumulator pair
        MODE_DIRECT,      // 16-bit direct operand
        MODE_SHORT,       // Short direct operand
        MODE_SFR,         // Special register operand
        MODE_REG,         // General register operand
        MODE_INDIRECT,    // Pointer pair indirect operand
        MODE_BASED,       // Base pointer plus displacement
        MODE_STACK_PUSH,  // Stack write (push, call, save)
        MODE_STACK_POP    // Stack read (pop, return, restore)
    } mode_t;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    localparam int REG_COUNT = 8;
    localparam int REG_CODE_W = 3;

    // ==========================================================
    // General register numbering: X A C B E D L H
    // ==========================================================
    localparam logic [1:0] PAIR_ACC = 2'h0;   // Accumulator pair, X low A high
    localparam logic [1:0] PAIR_TWO = 2'h2;   // Pointer pair two, E low D high
    localparam logic [1:0] PAIR_BASE = 2'h3;  // Base pointer pair, L low H high

    // ==========================================================
    // Vector table and fixed windows
    // ==========================================================
    localparam logic [9:0] TABLE_BASE_HIGH = 10'h001;  // Upper bits giving table at 40H
    localparam int VEC_LSB = 1;                         // Vector index field position
    localparam int VEC_MSB = 5;
    localparam logic [6:0] SHORT_HIGH = 7'h7F;          // Bits 15..9 of short address
    localparam logic [7:0] SHORT_SFR_LIMIT = 8'h20;     // Below this, bit 8 is set
    localparam logic [7:0] SFR_HIGH = 8'hFF;            // Upper byte of register area
    localparam logic [7:0] SFR_HOLE_LO = 8'hD0;         // Gap not reachable by this form
    localparam logic [7:0] SFR_HOLE_HI = 8'hDF;
    localparam logic [15:0] STACK_STEP = 16'h0001;      // Pre-decrement on writes

endpackage : cpu_address_generation_pkg

// ===== verification/cpu_address_generation_props.sv
// Port-level assertions for the address generation block
`timescale 1ns/10ps
`default_nettype none
module cpu_address_generation_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic req_valid,
    input wire cpu_address_generation_pkg::mode_t req_mode,
    input wire logic [7:0] opcode,
    input wire logic [15:0] absolute_address_field,
    input wire logic [7:0] byte_field,
    input wire logic [2:0] reg_code,
    input wire logic use_base_pair,
    input wire logic word_access,
    input wire logic [63:0] gpr,
    input wire logic [15:0] sp,
    input wire logic tbl_valid,
    input wire logic [15:0] tbl_data,
    input wire logic busy,
    input wire logic pc_load,
    input wire logic [15:0] pc_target,
    input wire logic ea_valid,
    input wire logic [15:0] ea,
    input wire logic ea_is_sfr,
    input wire logic [2:0] reg_index,
    input wire logic [7:0] reg_data,
    input wire logic tbl_rd_req,
    input wire logic [15:0] tbl_addr,
    input wire logic addr_error
);
    // ==========================================================
    // Helpers: accepted mode as one-hot, candidate addresses
    // ==========================================================
    logic [10:0] take;      // Bit n high when a mode n request is taken
    logic [7:0] sel_reg;    // Register picked by the code
    logic [15:0] acc_pair;  // X low byte, A high byte
    logic [15:0] ind_ptr;   // Pointer pair chosen for indirect
    logic [15:0] based_sum; // Width drops the carry out
    logic [15:0] push_addr;
    logic [15:0] vec_addr;
    logic odd_word;         // Word operand at an odd short address
    logic in_hole;          // Field inside the unreachable register gap
    assign take = (req_valid && ce && !busy) ? (11'h001 << req_mode) : 11'h000;
    assign sel_reg = gpr[reg_code * 8 +: 8];
    assign acc_pair = gpr[15:0];
    assign ind_ptr = use_base_pair ? gpr[63:48] : gpr[47:32];
    assign based_sum = gpr[63:48] + {8'h00, byte_field};
    assign push_addr = sp - 16'h0001;
    assign vec_addr = {10'h001, opcode[5:1], 1'b0};
    assign odd_word = word_access & byte_field[0];
    assign in_hole = (byte_field >= 8'hD0) && (byte_field <= 8'hDF);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ==========================================================
    // Checks, at least one per addressing form
    // ==========================================================
    property p_abs; take[0] |=> pc_load && pc_target == $past(absolute_address_field); endproperty
    a_abs: assert property (p_abs) else $error("absolute target wrong");
    property p_tbl; take[1] |=> tbl_rd_req && busy && tbl_addr == $past(vec_addr); endproperty
    a_tbl: assert property (p_tbl) else $error("vector read wrong");
    property p_tret; busy && ce && tbl_valid |=> pc_load && !busy && pc_target == $past(tbl_data); endproperty
    a_tret: assert property (p_tret) else $error("vector load wrong");
    property p_regbr; take[2] |=> pc_load && !ea_valid && pc_target == $past(acc_pair); endproperty
    a_regbr: assert property (p_regbr) else $error("pair branch wrong");
    property p_direct; take[3] |=> ea_valid && !pc_load && ea == $past(absolute_address_field); endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");
    property p_short; take[4] |=> ea_valid && ea_is_sfr == ($past(byte_field) < 8'h20)
        && ea == {7'h7F, $past(byte_field) < 8'h20, $past(byte_field)}; endproperty
    a_short: assert property (p_short) else $error("short address wrong");
    property p_sfr; take[5] |=> ea_valid && ea_is_sfr && ea == {8'hFF, $past(byte_field)}; endproperty
    a_sfr: assert property (p_sfr) else $error("register area address wrong");
    property p_reg; take[6] |=> !ea_valid && reg_index == $past(reg_code) && reg_data == $past(sel_reg); endproperty
    a_reg: assert property (p_reg) else $error("register select wrong");
    property p_ind; take[7] |=> ea_valid && ea == $past(ind_ptr); endproperty
    a_ind: assert property (p_ind) else $error("indirect address wrong");
    property p_based; take[8] |=> ea_valid && ea == $past(based_sum); endproperty
    a_based: assert property (p_based) else $error("based address wrong");
    property p_stack; take[9] |=> ea_valid && ea == $past(push_addr); endproperty
    a_stack: assert property (p_stack) else $error("stack address wrong");
    property p_pop; take[10] |=> ea_valid && !ea_is_sfr && ea == $past(sp); endproperty
    a_pop: assert property (p_pop) else $error("pop address wrong");
    property p_odd; take[4] |=> addr_error == $past(odd_word); endproperty
    a_odd: assert property (p_odd) else $error("odd word flag wrong");
    property p_hole; take[5] |=> addr_error == $past(in_hole); endproperty
    a_hole: assert property (p_hole) else $error("register gap flag wrong");
endmodule : cpu_address_generation_props
bind cpu_address_generation cpu_address_generation_props u_props (
    .clk, .srst, .ce, .req_valid, .req_mode, .opcode, .absolute_address_field, .byte_field, .reg_code,
    .use_base_pair, .word_access, .gpr, .sp, .tbl_valid, .tbl_data, .busy, .pc_load, .pc_target,
    .ea_valid, .ea, .ea_is_sfr, .reg_index, .reg_data, .tbl_rd_req, .tbl_addr, .addr_error
);
`default_nettype wire

// ===== verification/vector_memory_model.sv
// Behavioural vector table memory answering the block's reads
`timescale 1ns/10ps
`default_nettype none
module vector_memory_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic tbl_rd_req,
    input wire logic [15:0] tbl_addr,
    input wire logic [3:0] lat,
    output logic tbl_valid,
    output logic [15:0] tbl_data
);
    logic [3:0] cnt = 4'h0; // Wait cycles spent on the open read
    initial tbl_valid = 1'b0;
    initial tbl_data = 16'h0000;
    // One-cycle answer after lat idle cycles; data toggles when not valid
    always @(posedge clk)
    begin
        tbl_valid <= 1'b0;
        tbl_data <= ~tbl_data;
        if (srst || !tbl_rd_req || tbl_valid)
            cnt <= 4'h0;
        else if (cnt == lat)
        begin
            tbl_valid <= 1'b1;
            tbl_data <= tbl_addr ^ 16'hA5C3;
        end
        else
            cnt <= cnt + 4'h1;
    end
endmodule : vector_memory_model
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the address generation block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk, busy, pc_load, ea_valid, ea_is_sfr, tbl_rd_req, addr_error, tbl_valid;
    logic srst = 1'b1, ce = 1'b1, req_valid = 1'b0, use_base_pair = 1'b0, word_access = 1'b0;
    cpu_address_generation_pkg::mode_t req_mode = cpu_address_generation_pkg::MODE_ABS_BRANCH;
    logic [7:0] opcode = 8'h00, byte_field = 8'h00, reg_data;
    logic [15:0] absolute_address_field = 16'h0000, sp = 16'hFE80; // Stack kept in RAM
    logic [63:0] gpr = 64'hFEDC_BA98_7654_3210; // H L D E B C A X
    logic [15:0] tbl_data, pc_target, ea, tbl_addr;
    logic [2:0] reg_code = 3'h0, reg_index;
    logic [3:0] lat = 4'h0;
    int miscompares = 0;
    int total_checks = 0;
    // Row: mode code, immediate, byte, {base pair, word}, expected, {pc, error, check sfr, sfr}
    typedef struct packed {logic [3:0] m; logic [15:0] a; logic [7:0] b;
        logic [1:0] uw; logic [15:0] x; logic [3:0] f;} row_t;
    row_t rows [18] = '{'{4'h0, 16'h1234, 8'h00, 2'h0, 16'h1234, 4'h8}, '{4'h2, 16'h0, 8'h00, 2'h0, 16'h3210, 4'h8},
        '{4'h3, 16'hFE00, 8'h00, 2'h0, 16'hFE00, 4'h0}, '{4'h4, 16'h0, 8'h20, 2'h0, 16'hFE20, 4'h2},
        '{4'h4, 16'h0, 8'hFF, 2'h0, 16'hFEFF, 4'h2}, '{4'h4, 16'h0, 8'h00, 2'h0, 16'hFF00, 4'h3},
        '{4'h4, 16'h0, 8'h1F, 2'h0, 16'hFF1F, 4'h3}, '{4'h4, 16'h0, 8'h05, 2'h1, 16'hFF05, 4'h7},
        '{4'h4, 16'h0, 8'h22, 2'h1, 16'hFE22, 4'h2}, '{4'h5, 16'h0, 8'h1F, 2'h0, 16'hFF1F, 4'h3},
        '{4'h5, 16'h0, 8'hCF, 2'h0, 16'hFFCF, 4'h3}, '{4'h5, 16'h0, 8'hE0, 2'h0, 16'hFFE0, 4'h3},
        '{4'h5, 16'h0, 8'hD0, 2'h0, 16'hFFD0, 4'h7}, '{4'h7, 16'h0, 8'h00, 2'h0, 16'hBA98, 4'h0},
        '{4'h7, 16'h0, 8'h00, 2'h2, 16'hFEDC, 4'h0}, '{4'h8, 16'h0, 8'h10, 2'h0, 16'hFEEC, 4'h0},
        '{4'h9, 16'h0, 8'h00, 2'h0, 16'hFE7F, 4'h0}, '{4'hA, 16'h0, 8'h00, 2'h0, 16'hFE80, 4'h0}};
    cpu_address_generation u_cpu_address_generation (.clk, .srst, .ce, .req_valid, .req_mode, .opcode,
        .absolute_address_field, .byte_field, .reg_code, .use_base_pair, .word_access, .gpr, .sp, .tbl_valid,
        .tbl_data, .busy, .pc_load, .pc_target, .ea_valid, .ea, .ea_is_sfr, .reg_index, .reg_data, .tbl_rd_req,
        .tbl_addr, .addr_error);
    vector_memory_model u_vector_memory_model (.clk, .srst, .tbl_rd_req, .tbl_addr, .lat, .tbl_valid, .tbl_data);
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Present a request at an edge; opcode bits 5..1 carry the vector index
    task automatic put(input logic [3:0] m, input logic [15:0] a, input logic [7:0] b, input logic [2:0] r,
        input logic [1:0] uw);
        @(posedge clk);
        req_valid <= 1'b1;
        req_mode <= cpu_address_generation_pkg::mode_t'(m);
        absolute_address_field <= a;
        byte_field <= b;
        opcode <= {2'h3, b[4:0], 1'b1};
        reg_code <= r;
        {use_base_pair, word_access} <= uw;
    endtask : put
    // Release at the accepting edge, then let outputs settle
    task automatic done();
        @(posedge clk) req_valid <= 1'b0;
        #1;
    endtask : done
    // Table call with a request held while busy; taken only once the vector lands
    task automatic tcall(input logic [4:0] idx, input logic [3:0] l);
        logic [15:0] ta;
        ta = 16'h0040 + {10'h000, idx, 1'b0};
        put(4'h1, 16'h0000, {3'h0, idx}, 3'h0, 2'h0);
        lat <= l;
        done();
        chk(tbl_addr, ta);
        chk({busy, tbl_rd_req}, 16'h0003);
        put(4'h3, 16'hABCD, 8'h00, 3'h0, 2'h0);
        #1;
        for (int n = 0; n < 30 && pc_load !== 1'b1; n++)
        begin
            chk(ea_valid, 16'h0000);
            @(posedge clk);
            #1;
        end
        chk({pc_load, tbl_rd_req, busy}, 16'h0004);
        chk(pc_target, ta ^ 16'hA5C3);
        done();
        chk(ea, 16'hABCD);
    endtask : tcall
    task automatic wrap_up();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog, far beyond the hundred or so cycles the run needs
    initial
    begin
        repeat (3000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial
    begin
        repeat (11) @(posedge clk);
        #1;
        chk({busy, pc_load, ea_valid, tbl_rd_req, addr_error}, 16'h0000);
        @(posedge clk) srst <= 1'b0;
        foreach (rows[i])
        begin
            put(rows[i].m, rows[i].a, rows[i].b, 3'h0, rows[i].uw);
            done();
            chk(pc_load, rows[i].f[3]);
            chk(ea_valid, !rows[i].f[3]);
            chk(rows[i].f[3] ? pc_target : ea, rows[i].x);
            chk(addr_error, rows[i].f[2]);
            if (rows[i].f[1])
                chk(ea_is_sfr, rows[i].f[0]);
        end
        for (int i = 0; i < 8; i++)
        begin
            put(4'h6, 16'h0000, 8'h00, 3'(i), 2'h0);
            done();
            chk(reg_index, 16'(i));
            chk(reg_data, 16'h0010 + 16'(i) * 16'h0022);
        end
        tcall(5'h00, 4'h0);
        // Back to back, then based sum that wraps
        put(4'h3, 16'hFFFF, 8'h00, 3'h0, 2'h0);
        gpr <= {16'hFFF0, gpr[47:0]};
        put(4'h8, 16'h0000, 8'h20, 3'h0, 2'h0);
        #1;
        chk(ea, 16'hFFFF);
        done();
        chk(ea, 16'h0010);
        // Frozen strobe while the clock enable is low
        put(4'h9, 16'h0000, 8'h00, 3'h0, 2'h0);
        @(posedge clk) req_valid <= 1'b0;
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(ea_valid, 16'h0001);
        chk(ea, 16'hFE7F);
        @(posedge clk) ce <= 1'b1;
        @(posedge clk);
        #1;
        chk(ea_valid, 16'h0000);
        // Undefined mode code: only the error strobe answers
        put(4'hB, 16'h0000, 8'h00, 3'h0, 2'h0);
        done();
        chk({pc_load, ea_valid, addr_error}, 16'h0001);
        // Reset while a vector read is open
        put(4'h1, 16'h0000, 8'h03, 3'h0, 2'h0);
        lat <= 4'hF;
        @(posedge clk) req_valid <= 1'b0;
        srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        #1;
        chk({busy, tbl_rd_req, pc_load}, 16'h0000);
        tcall(5'h1F, 4'h7);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
